// File: core/blocking_pilot_trip_logic.sv
// blocking pilot trip and carrier control logic
`timescale 1ns/10ps
`include "blocking_pilot_params.svh"
module blocking_pilot_trip_logic
  import blocking_pilot_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYCLES
)
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_blocking_scheme_sel,
  input wire carrier_start_select_t i_carrier_start_select,
  input wire logic i_restraint_factor_setting,
  input wire ms_count_t i_coordination_ms,
  input wire func_group_t i_trip_funcs,
  input wire func_group_t i_block_funcs,
  input wire logic i_residual_overcurrent_detector,
  input wire logic i_ground_reverse_direction_unit,
  input wire logic i_disturbance_detector,
  input wire logic i_out_of_step_block,
  input wire logic i_three_terminal,
  input wire logic i_receiver_input_one,
  input wire logic i_receiver_input_two,
  input wire logic i_stop_carrier_input,
  input wire logic i_pilot_block_input,
  output logic o_zone4_reverse,
  output logic o_residual_restraint,
  output logic o_carrier_start,
  output logic o_carrier_stop,
  output logic o_trip
);

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  pilot_state_t st;
  pilot_state_t next_st;

  logic any_trip;
  logic dist_block_raw;
  logic dist_block_eff;
  logic ground_directional_overcurrent_block_eff;
  logic ground_persist;
  logic dist_persist;
  logic ground_block_ext;
  logic dist_block_ext;
  logic any_block_ext;
  logic ground_start;
  logic receiver_block;
  logic comparator;
  logic coord_out;
  logic stop_any;

  // overreaching trip functions, any of them
  assign any_trip = i_trip_funcs.phase
    | i_trip_funcs.ground_dist
    | i_trip_funcs.ground_directional_overcurrent;

  // blocking inhibit gate: trip functions win over blocking
  assign dist_block_raw = i_block_funcs.phase | i_block_funcs.ground_dist;
  assign dist_block_eff = dist_block_raw & ~any_trip;
  assign ground_directional_overcurrent_block_eff = i_block_funcs.ground_directional_overcurrent & ~any_trip;

  // ground directional transient block
  ms_timer u_ground_block_persist_timer (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_tick(st.tick),
    .i_in(ground_directional_overcurrent_block_eff),
    .i_pickup_ms(`GROUND_PERSIST_MS),
    .i_dropout_ms(`GROUND_EXTEND_MS),
    .o_out(ground_persist)
  );

  // distance transient block
  ms_timer u_distance_block_persist_timer (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_tick(st.tick),
    .i_in(dist_block_eff),
    .i_pickup_ms(`DIST_PERSIST_MS),
    .i_dropout_ms(`DIST_EXTEND_MS),
    .o_out(dist_persist)
  );

  assign ground_block_ext = ground_directional_overcurrent_block_eff | ground_persist;
  assign dist_block_ext = dist_block_eff | dist_persist;
  assign any_block_ext = ground_block_ext | dist_block_ext;

  // ground carrier start choice
  always_comb begin
    unique case (i_carrier_start_select)
      CS_DIRECTIONAL: begin
        ground_start = i_residual_overcurrent_detector
          & i_ground_reverse_direction_unit;
      end
      CS_RESIDUAL: begin
        ground_start = i_residual_overcurrent_detector;
      end
      CS_DISTURBANCE: begin
        ground_start = i_disturbance_detector;
      end
      default: begin
        ground_start = 1'b0;
      end
    endcase
  end

  // either receiver blocks; second only on three terminals
  assign receiver_block = i_receiver_input_one
    | (i_three_terminal & i_receiver_input_two);

  assign comparator = any_trip
    & ~receiver_block
    & ~any_block_ext
    & ~i_out_of_step_block
    & ~i_pilot_block_input;

  // coordination time before trip may issue
  ms_timer u_coordination_timer (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_tick(st.tick),
    .i_in(comparator),
    .i_pickup_ms(i_coordination_ms),
    .i_dropout_ms(`COORD_DROPOUT_MS),
    .o_out(coord_out)
  );

  assign stop_any = any_trip | i_stop_carrier_input;

  always_comb begin
    next_st = st;
    // millisecond tick
    if (st.tick_cnt >= TICK_LAST) begin
      next_st.tick_cnt = 16'h0000;
      next_st.tick = 1'b1;
    end else begin
      next_st.tick_cnt = st.tick_cnt + 16'h0001;
      next_st.tick = 1'b0;
    end
    next_st.zone4_reverse = i_blocking_scheme_sel;
    next_st.restraint = i_restraint_factor_setting
      & (i_carrier_start_select != CS_DISTURBANCE);
    // keying: blocks start, trip functions or stop contact stop
    next_st.carrier_start = (any_block_ext | ground_start) & ~stop_any;
    next_st.carrier_stop = stop_any;
    next_st.trip = coord_out & i_disturbance_detector
      & ~i_pilot_block_input;
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_zone4_reverse = st.zone4_reverse;
  assign o_residual_restraint = st.restraint;
  assign o_carrier_start = st.carrier_start;
  assign o_carrier_stop = st.carrier_stop;
  assign o_trip = st.trip;

  // checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  chk_zone4_follow: assert property (
    ##1 o_zone4_reverse == $past(i_blocking_scheme_sel)
  ) else $error("zone four reach does not follow scheme select");

  chk_block_keys: assert property (
    (any_block_ext && !stop_any) |=> o_carrier_start
  ) else $error("blocking function did not key carrier");

  chk_trip_stops: assert property (
    any_trip |=> (o_carrier_stop && !o_carrier_start)
  ) else $error("trip function did not stop carrier");

  chk_start_legal: assert property (
    (i_carrier_start_select == 2'h3) |-> !ground_start
  ) else $error("illegal carrier start choice started carrier");

  chk_dir_start: assert property (
    (i_carrier_start_select == CS_DIRECTIONAL)
      |-> (ground_start == (i_residual_overcurrent_detector
        && i_ground_reverse_direction_unit))
  ) else $error("directional start is not an and of both units");

  chk_residual_start: assert property (
    (i_carrier_start_select == CS_RESIDUAL)
      |-> (ground_start == i_residual_overcurrent_detector)
  ) else $error("residual start not driven by residual detector");

  chk_fd_start: assert property (
    (i_carrier_start_select == CS_DISTURBANCE)
      |-> (ground_start == i_disturbance_detector)
  ) else $error("disturbance start not driven by disturbance detector");

  chk_restraint_sel: assert property (
    (i_carrier_start_select == CS_DISTURBANCE) |=> !o_residual_restraint
  ) else $error("restraint applied under disturbance choice");

  chk_start_stop_excl: assert property (
    !(o_carrier_start && o_carrier_stop)
  ) else $error("carrier start and stop both asserted");

  chk_trip_inhibits: assert property (
    any_trip |-> (!dist_block_eff && !ground_directional_overcurrent_block_eff)
  ) else $error("blocking function not inhibited by trip function");

  chk_trip_cause: assert property (
    o_trip |-> $past(coord_out)
  ) else $error("trip issued without coordination timer output");

  chk_oos_block: assert property (
    i_out_of_step_block[*2] |=> ##1 !o_trip
  ) else $error("trip issued during out of step block");

  chk_fd_gate: assert property (
    o_trip |-> $past(i_disturbance_detector)
  ) else $error("trip issued without disturbance");

  chk_rcv_blocks: assert property (
    i_receiver_input_one[*2] |=> ##1 !o_trip
  ) else $error("received block did not stop trip");

  chk_local_blocks: assert property (
    any_block_ext |-> !comparator
  ) else $error("local block did not block comparator");

  chk_ground_extend: assert property (
    ($fell(ground_directional_overcurrent_block_eff) && ground_persist) |-> ground_block_ext[*8]
  ) else $error("ground block not extended after dropout");

  chk_rcv_two: assert property (
    (i_three_terminal && i_receiver_input_two) |-> !comparator
  ) else $error("second receiver did not block on three terminals");

  chk_stop_input: assert property (
    i_stop_carrier_input |=> (!o_carrier_start && o_carrier_stop)
  ) else $error("stop carrier input did not force transmitter off");

  chk_pilot_block: assert property (
    i_pilot_block_input |=> !o_trip
  ) else $error("trip issued while pilot blocked");

  chk_tick_single: assert property (
    (st.tick && TICK_CYCLES > 1) |=> !st.tick
  ) else $error("millisecond tick wider than one cycle");

  // comparator and final trip gating
  chk_comp_needs_trip: assert property (
    comparator |-> any_trip
  ) else $error("comparator set without a trip function");

  chk_trip_after_comp: assert property (
    o_trip |-> $past(comparator, 2)
  ) else $error("trip issued without comparator two cycles earlier");

  chk_coord_zero: assert property (
    (comparator && i_coordination_ms == 8'h00)
      |=> coord_out
  ) else $error("zero coordination time did not pass comparator");

  chk_oos_comp: assert property (
    i_out_of_step_block |-> !comparator
  ) else $error("out of step block did not hold comparator");

  chk_trip_follows: assert property (
    (coord_out && i_disturbance_detector && !i_pilot_block_input)
      |=> o_trip
  ) else $error("trip not issued after coordination time");

  chk_no_fd_no_trip: assert property (
    !i_disturbance_detector |=> !o_trip
  ) else $error("trip issued with no disturbance present");

  chk_rcv_one_comp: assert property (
    i_receiver_input_one |-> !comparator
  ) else $error("first receiver did not hold comparator");

  chk_rx_two_trip: assert property (
    (i_three_terminal && i_receiver_input_two)
      |=> ##1 !o_trip
  ) else $error("second receiver did not stop trip");

  chk_pilot_comp: assert property (
    i_pilot_block_input |-> !comparator
  ) else $error("pilot block did not hold comparator");

  // carrier keying sources and restraint output
  chk_start_source: assert property (
    o_carrier_start |-> $past(any_block_ext || ground_start)
  ) else $error("carrier started with no start cause");

  chk_ground_keys: assert property (
    (ground_start && !stop_any) |=> o_carrier_start
  ) else $error("ground start choice did not key carrier");

  chk_stop_source: assert property (
    o_carrier_stop |-> $past(any_trip || i_stop_carrier_input)
  ) else $error("carrier stopped with no stop cause");

  chk_stop_keeps_off: assert property (
    $past(i_stop_carrier_input) |-> !o_carrier_start
  ) else $error("carrier started while stop carrier input held");

  chk_restraint_follow: assert property (
    (i_carrier_start_select != CS_DISTURBANCE)
      |=> (o_residual_restraint == $past(i_restraint_factor_setting))
  ) else $error("restraint output does not follow its setting");

  // transient blocking timers
  chk_ground_arm_src: assert property (
    $rose(ground_persist) |-> $past(ground_directional_overcurrent_block_eff)
  ) else $error("ground persist timer armed without ground block");

  chk_ground_comp: assert property (
    ground_persist |-> !comparator
  ) else $error("armed ground block did not hold comparator");

  chk_dist_arm_src: assert property (
    $rose(dist_persist) |-> $past(dist_block_eff)
  ) else $error("distance persist timer armed without distance block");

  chk_dist_comp: assert property (
    dist_persist |-> !comparator
  ) else $error("armed distance block did not hold comparator");

  chk_dist_extend: assert property (
    ($fell(dist_block_eff) && dist_persist) |-> dist_block_ext[*8]
  ) else $error("distance block not extended after dropout");

  chk_dist_inhibit: assert property (
    (dist_block_raw && any_trip) |-> !dist_block_eff
  ) else $error("distance block not reset by trip function");

  // millisecond tick counter
  chk_tick_wrap: assert property (
    st.tick |-> (st.tick_cnt == 16'h0000)
  ) else $error("tick not aligned with counter wrap");

  chk_tick_range: assert property (
    st.tick_cnt <= TICK_LAST
  ) else $error("tick counter beyond its last count");

endmodule : blocking_pilot_trip_logic

// File: core/blocking_pilot_params.svh
// constants for the blocking pilot trip logic
`ifndef BLOCKING_PILOT_PARAMS_SVH
`define BLOCKING_PILOT_PARAMS_SVH

`define CLK_PERIOD_NS 100
`define MS_IN_NS 1000000
`define TICK_CYCLES (`MS_IN_NS / `CLK_PERIOD_NS)
`define TICK_CNT_W 16
`define MS_CNT_W 8

`define GROUND_PERSIST_MS 8'h19
`define GROUND_EXTEND_MS 8'h1e
`define DIST_PERSIST_MS 8'h19
`define DIST_EXTEND_MS 8'h1e
`define COORD_DROPOUT_MS 8'h00

`endif

// File: core/blocking_pilot_pkg.sv
// types for the blocking pilot trip logic
package blocking_pilot_pkg;

  typedef enum logic [1:0] {
    CS_DIRECTIONAL = 2'h0,
    CS_RESIDUAL = 2'h1,
    CS_DISTURBANCE = 2'h2
  } carrier_start_select_t;

  typedef logic [7:0] ms_count_t;

  typedef struct packed {
    logic phase;
    logic ground_dist;
    logic ground_directional_overcurrent;
  } func_group_t;

  typedef struct packed {
    ms_count_t up;
    ms_count_t down;
    logic out;
  } ms_timer_state_t;

  typedef struct packed {
    logic [15:0] tick_cnt;
    logic tick;
    logic carrier_start;
    logic carrier_stop;
    logic trip;
    logic restraint;
    logic zone4_reverse;
  } pilot_state_t;

endpackage : blocking_pilot_pkg

// File: core/ms_timer.sv
// pickup and dropout timer on a millisecond tick
`timescale 1ns/10ps
module ms_timer
  import blocking_pilot_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_tick,
  input wire logic i_in,
  input wire ms_count_t i_pickup_ms,
  input wire ms_count_t i_dropout_ms,
  output logic o_out
);

  ms_timer_state_t st;
  ms_timer_state_t next_st;

  always_comb begin
    next_st = st;
    if (i_in) begin
      // pickup counts while held
      next_st.down = i_dropout_ms;
      if (st.up >= i_pickup_ms) begin
        next_st.out = 1'b1;
      end else if (i_tick) begin
        next_st.up = st.up + 8'h01;
      end
    end else begin
      // dropout extension counts after fall
      next_st.up = 8'h00;
      if (st.out) begin
        if (st.down == 8'h00) begin
          next_st.out = 1'b0;
        end else if (i_tick) begin
          next_st.down = st.down - 8'h01;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_out = st.out;

endmodule : ms_timer

// File: verification/remote_terminal_model.sv
// far-end terminal with its on-off carrier set
`timescale 1ns/10ps
module remote_terminal_model (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ext_fault,
  input wire logic i_slow,
  output logic o_receiver
);
  logic [3:0] age;
  // carrier absent means the receiver contact stays open
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || !i_ext_fault) begin
      age <= 4'h0;
      o_receiver <= 1'b0;
    end else begin
      age <= (age == 4'hf) ? age : age + 4'h1;
      o_receiver <= (age >= (i_slow ? 4'h7 : 4'h0));
    end
  end
endmodule : remote_terminal_model

// File: verification/test_blocking_pilot_trip_logic.sv
// self-checking bench for the blocking pilot trip logic
`timescale 1ns/10ps
`include "blocking_pilot_params.svh"
module test_blocking_pilot_trip_logic
  import blocking_pilot_pkg::*;
;
  localparam int T = 10;
  localparam int EXT = `GROUND_EXTEND_MS;
  localparam int PER = `GROUND_PERSIST_MS;
  logic i_clk, rst_n, scheme, rfs, res, rev, fd, oos, three, rx1, rx2;
  logic stop_in, pblk, ext, slow, z4, rr, cs, cp, tr;
  carrier_start_select_t csel;
  ms_count_t coord;
  func_group_t trf, blf;
  logic [4:0] q[$];
  event chk_ev;
  int bad_count = 0;
  int compares = 0;
  logic g;

  blocking_pilot_trip_logic #(.TICK_CYCLES(T)) dut_u (
    .i_clk(i_clk), .i_reset_n(rst_n), .i_blocking_scheme_sel(scheme),
    .i_carrier_start_select(csel), .i_restraint_factor_setting(rfs),
    .i_coordination_ms(coord), .i_trip_funcs(trf), .i_block_funcs(blf),
    .i_residual_overcurrent_detector(res), .i_ground_reverse_direction_unit(rev),
    .i_disturbance_detector(fd), .i_out_of_step_block(oos), .i_three_terminal(three),
    .i_receiver_input_one(rx1), .i_receiver_input_two(rx2),
    .i_stop_carrier_input(stop_in), .i_pilot_block_input(pblk),
    .o_zone4_reverse(z4), .o_residual_restraint(rr), .o_carrier_start(cs),
    .o_carrier_stop(cp), .o_trip(tr)
  );

  remote_terminal_model far_u (
    .i_clk(i_clk), .i_reset_n(rst_n), .i_ext_fault(ext), .i_slow(slow), .o_receiver(rx1)
  );

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask : cyc

  // note the expected outputs, hand them to the monitor, return on a rising edge
  task automatic expect_out(input logic s, input logic p, input logic t);
    @(negedge i_clk);
    q.push_back({scheme, rfs & (csel != CS_DISTURBANCE), s, p, t});
    -> chk_ev;
    @(posedge i_clk);
  endtask : expect_out

  task automatic check_out(input logic [4:0] exp);
    compares++;
    if ({z4, rr, cs, cp, tr} !== exp) begin
      bad_count++;
      $display("Error t=%0t exp=%h got=%h", $time, exp, {z4, rr, cs, cp, tr});
    end
  endtask : check_out

  task automatic end_sim;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  initial begin
    forever begin
      @(chk_ev);
      check_out(q.pop_front());
    end
  end

  initial begin
    cyc(5000);
    bad_count++;
    end_sim();
  end

  initial begin
    {rst_n, scheme, rfs, res, rev, fd, oos, three, rx2, stop_in, pblk, ext} = '0;
    csel = CS_DIRECTIONAL;
    coord = 8'h00;
    trf = '0;
    blf = '0;
    slow = 1'b1;
    void'($urandom(57));
    cyc(20);
    rst_n <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      cyc(1);
      csel <= carrier_start_select_t'(2'(i));
      {res, rev, fd} <= 3'($urandom);
      {scheme, rfs} <= 2'($urandom);
      cyc(2);
      case (csel)
        CS_DIRECTIONAL: g = res & rev;
        CS_RESIDUAL: g = res;
        CS_DISTURBANCE: g = fd;
        default: g = 1'b0;
      endcase
      expect_out(g, 1'b0, 1'b0);
    end
    $display("test start modes done");
    cyc(1);
    {res, rev, fd} <= 3'h0;
    csel <= CS_RESIDUAL;
    blf <= 3'h4;
    cyc(2);
    expect_out(1'b1, 1'b0, 1'b0);
    trf <= 3'h4;
    cyc(2);
    expect_out(1'b0, 1'b1, 1'b0);
    fd <= 1'b1;
    cyc(3);
    expect_out(1'b0, 1'b1, 1'b1);
    trf <= 3'h0;
    stop_in <= 1'b1;
    cyc(2);
    expect_out(1'b0, 1'b1, 1'b0);
    blf <= 3'h0;
    stop_in <= 1'b0;
    $display("test carrier keying done");
    for (int k = 0; k < 6; k++) begin
      cyc(1);
      slow <= 1'($urandom);
      ext <= (k == 0);
      {three, rx2} <= {2{k == 1}};
      oos <= (k == 2);
      pblk <= (k == 3);
      fd <= (k != 4);
      cyc(12);
      trf <= 3'h1;
      cyc(4);
      expect_out(1'b0, 1'b1, k == 5);
      cyc(1);
      trf <= 3'h0;
    end
    $display("test trip refusals done");
    cyc(3);
    coord <= 8'h03;
    trf <= 3'h2;
    cyc(2 * T);
    expect_out(1'b0, 1'b1, 1'b0);
    cyc(2 * T + 5);
    expect_out(1'b0, 1'b1, 1'b1);
    trf <= 3'h0;
    coord <= 8'h00;
    $display("test coordination done");
    for (int b = 0; b < 2; b++) begin
      cyc(1);
      blf <= (b == 0) ? 3'h1 : 3'h2;
      cyc((PER + 2) * T);
      blf <= 3'h0;
      cyc((EXT - 10) * T);
      expect_out(1'b1, 1'b0, 1'b0);
      trf <= 3'h4;
      cyc(3 * T);
      expect_out(1'b0, 1'b1, 1'b0);
      cyc(10 * T);
      expect_out(1'b0, 1'b1, 1'b1);
      trf <= 3'h0;
    end
    blf <= 3'h1;
    cyc((PER - 5) * T);
    blf <= 3'h0;
    cyc(3 * T);
    expect_out(1'b0, 1'b0, 1'b0);
    $display("test transient block done");
    end_sim();
  end
endmodule : test_blocking_pilot_trip_logic
